/* File: src/mbrw_regs.svh */
// constants for the identification and read/write-multiple command interpreter
`ifndef MBRW_REGS_SVH
`define MBRW_REGS_SVH

// function codes and exception marker
`define MBRW_FC_ID 8'h11
`define MBRW_FC_RW 8'h17
`define MBRW_ERR_FLAG 8'h80

// exception codes
`define MBRW_EXC_FUNC 8'h01
`define MBRW_EXC_ADDR 8'h02
`define MBRW_EXC_VALUE 8'h03
`define MBRW_EXC_FAIL 8'h04

// identification answer fields and answer lengths
`define MBRW_ID_COUNT 8'h02
`define MBRW_RUN_ON 8'hff
`define MBRW_RUN_OFF 8'h00
`define MBRW_ID_LEN 8'h05
`define MBRW_EXC_LEN 8'h03
`define MBRW_RW_HDR_LEN 8'h03

// request layout: byte positions and quantity limits
`define MBRW_RX_HDR_LEN 9'h00b
`define MBRW_ID_REQ_LEN 9'h002
`define MBRW_QTY_MIN 16'h0001
`define MBRW_QTY_MAX 16'h0079

`endif

/* File: src/mbrw_pkg.sv */
// types for the identification and read/write-multiple command interpreter
package mbrw_pkg;

    typedef enum logic [2:0] {
        MBRW_IDLE = 3'b000,
        MBRW_WR_REQ = 3'b001,
        MBRW_WR_WAIT = 3'b010,
        MBRW_RD_REQ = 3'b011,
        MBRW_RD_WAIT = 3'b100,
        MBRW_TX = 3'b101
    } mbrw_state_type;

    typedef enum logic [1:0] {
        MBRW_KIND_ID = 2'b00,
        MBRW_KIND_RW = 2'b01,
        MBRW_KIND_EXC = 2'b10
    } mbrw_kind_type;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mbrw_tx_type;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } mbrw_req_type;

endpackage

/* File: src/mbrw_server.sv */
// command interpreter for the server identification and read/write-multiple functions
`timescale 1ns/100ps
`include "mbrw_regs.svh"

module mbrw_server #(
    parameter int MAX_REGS = 121
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // received frame bytes, crc already stripped
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_end_in,
    input wire logic rx_crc_ok_in,
    // answer bytes toward the crc appender
    output mbrw_pkg::mbrw_tx_type tx_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // server address switches and device status
    input wire logic [7:0] server_addr_in,
    input wire logic run_status_in,
    input wire logic id_fault_in,
    // register store port and busy flag
    output logic req_valid_out,
    output mbrw_pkg::mbrw_req_type req_out,
    input wire logic req_ack_in,
    input wire logic [15:0] req_rdata_in,
    input wire logic req_err_in,
    output logic busy_out
);

    mbrw_pkg::mbrw_state_type st_q;
    mbrw_pkg::mbrw_kind_type kind_q;
    logic [7:0] addr_meta_q, own_q;
    logic [8:0] cnt_q;
    logic [7:0] sa_q, fc_q, bc_q, exc_q, tx_idx_q;
    logic [15:0] rs_q, rq_q, ws_q, wq_q;
    logic [6:0] n_q;
    logic [15:0] buf_q [MAX_REGS];
    logic tx_valid_q, req_valid_q, busy_q;
    mbrw_pkg::mbrw_tx_type tx_q;
    mbrw_pkg::mbrw_req_type req_q;

    // quantity must lie in the legal window and fit the buffer
    function automatic logic qty_ok(input logic [15:0] q);
        return (q >= `MBRW_QTY_MIN) && (q <= `MBRW_QTY_MAX) && (q <= 16'(MAX_REGS));
    endfunction

    // server address comes from switches: two-flop synchroniser
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_meta_q <= 8'h00;
            own_q <= 8'h00;
        end else begin
            addr_meta_q <= server_addr_in;
            own_q <= addr_meta_q;
        end
    end

    // frame acceptance decode
    wire frame_ok = (st_q == mbrw_pkg::MBRW_IDLE) && rx_end_in && rx_crc_ok_in && (sa_q == own_q);
    wire is_id = frame_ok && (fc_q == `MBRW_FC_ID) && (cnt_q == `MBRW_ID_REQ_LEN);
    wire is_rw = frame_ok && (fc_q == `MBRW_FC_RW);
    wire [8:0] rw_len = `MBRW_RX_HDR_LEN + {1'b0, bc_q};
    wire rw_ok = qty_ok(rq_q) && qty_ok(wq_q) && (bc_q == {wq_q[6:0], 1'b0}) && (cnt_q == rw_len);
    wire [8:0] pos = cnt_q - `MBRW_RX_HDR_LEN;
    wire data_byte = rx_valid_in && (cnt_q >= `MBRW_RX_HDR_LEN) && (32'(pos[8:1]) < MAX_REGS);
    wire n_last_wr = ({9'h000, n_q} == wq_q - 16'h0001);
    wire n_last_rd = ({9'h000, n_q} == rq_q - 16'h0001);

    // answer byte selection, high byte of each word first
    wire [7:0] j = tx_idx_q - `MBRW_RW_HDR_LEN;
    wire [15:0] tx_word = buf_q[j[7:1]];
    wire [7:0] word_byte = j[0] ? tx_word[7:0] : tx_word[15:8];
    wire [7:0] run_byte = run_status_in ? `MBRW_RUN_ON : `MBRW_RUN_OFF;
    wire is_exc = (kind_q == mbrw_pkg::MBRW_KIND_EXC);
    wire is_idk = (kind_q == mbrw_pkg::MBRW_KIND_ID);
    wire [7:0] tx_len = is_exc ? `MBRW_EXC_LEN : is_idk ? `MBRW_ID_LEN : 8'(`MBRW_RW_HDR_LEN + {rq_q[6:0], 1'b0});
    wire [7:0] tx_byte = (tx_idx_q == 8'h00) ? own_q :
                         (tx_idx_q == 8'h01) ? (is_exc ? (fc_q | `MBRW_ERR_FLAG) : fc_q) :
                         (tx_idx_q == 8'h02) ? (is_exc ? exc_q : is_idk ? `MBRW_ID_COUNT :
                                                {rq_q[6:0], 1'b0}) :
                         (tx_idx_q == 8'h03 && is_idk) ? own_q :
                         (tx_idx_q == 8'h04 && is_idk) ? run_byte :
                         word_byte;
    wire tx_load = (st_q == mbrw_pkg::MBRW_TX) && (!tx_valid_q || tx_ready_in) && (tx_idx_q < tx_len);

    // request field capture while idle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 9'h000;
            sa_q <= 8'h00;
            fc_q <= 8'h00;
            bc_q <= 8'h00;
            rs_q <= 16'h0000;
            rq_q <= 16'h0000;
            ws_q <= 16'h0000;
            wq_q <= 16'h0000;
        end else if (st_q == mbrw_pkg::MBRW_IDLE) begin
            if (rx_end_in) begin
                cnt_q <= 9'h000;
            end else if (rx_valid_in) begin
                if (cnt_q != 9'h1ff) begin
                    cnt_q <= cnt_q + 9'h001;
                end
                case (cnt_q)
                    9'h000: sa_q <= rx_data_in;
                    9'h001: fc_q <= rx_data_in;
                    9'h002: rs_q[15:8] <= rx_data_in;
                    9'h003: rs_q[7:0] <= rx_data_in;
                    9'h004: rq_q[15:8] <= rx_data_in;
                    9'h005: rq_q[7:0] <= rx_data_in;
                    9'h006: ws_q[15:8] <= rx_data_in;
                    9'h007: ws_q[7:0] <= rx_data_in;
                    9'h008: wq_q[15:8] <= rx_data_in;
                    9'h009: wq_q[7:0] <= rx_data_in;
                    9'h00a: bc_q <= rx_data_in;
                    default: ;
                endcase
            end
        end
    end

    // word buffer: write values on receive, read values from the store
    always_ff @(posedge clk_in) begin
        if (st_q == mbrw_pkg::MBRW_IDLE && data_byte && !pos[0]) begin
            buf_q[pos[7:1]][15:8] <= rx_data_in;
        end else if (st_q == mbrw_pkg::MBRW_IDLE && data_byte) begin
            buf_q[pos[7:1]][7:0] <= rx_data_in;
        end else if (st_q == mbrw_pkg::MBRW_RD_WAIT && req_ack_in && !req_err_in) begin
            buf_q[n_q] <= req_rdata_in;
        end
    end

    // transaction sequencer: check, write all, read all, answer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q <= mbrw_pkg::MBRW_IDLE;
            kind_q <= mbrw_pkg::MBRW_KIND_ID;
            exc_q <= 8'h00;
            n_q <= 7'h00;
            tx_idx_q <= 8'h00;
            req_valid_q <= 1'b0;
            req_q <= '0;
            tx_valid_q <= 1'b0;
            tx_q <= '0;
        end else begin
            case (st_q)
                mbrw_pkg::MBRW_IDLE: begin
                    tx_idx_q <= 8'h00;
                    n_q <= 7'h00;
                    if (is_id) begin
                        kind_q <= id_fault_in ? mbrw_pkg::MBRW_KIND_EXC : mbrw_pkg::MBRW_KIND_ID;
                        exc_q <= `MBRW_EXC_FAIL;
                        st_q <= mbrw_pkg::MBRW_TX;
                    end else if (is_rw && !rw_ok) begin
                        kind_q <= mbrw_pkg::MBRW_KIND_EXC;
                        exc_q <= `MBRW_EXC_VALUE;
                        st_q <= mbrw_pkg::MBRW_TX;
                    end else if (is_rw) begin
                        st_q <= mbrw_pkg::MBRW_WR_REQ;
                    end
                end
                mbrw_pkg::MBRW_WR_REQ: begin
                    req_valid_q <= 1'b1;
                    req_q <= '{write: 1'b1, addr: ws_q + 16'(n_q), data: buf_q[n_q]};
                    st_q <= mbrw_pkg::MBRW_WR_WAIT;
                end
                mbrw_pkg::MBRW_WR_WAIT: begin
                    if (req_ack_in) begin
                        req_valid_q <= 1'b0;
                        if (req_err_in) begin
                            kind_q <= mbrw_pkg::MBRW_KIND_EXC;
                            exc_q <= `MBRW_EXC_ADDR;
                            st_q <= mbrw_pkg::MBRW_TX;
                        end else if (n_last_wr) begin
                            n_q <= 7'h00;
                            st_q <= mbrw_pkg::MBRW_RD_REQ;
                        end else begin
                            n_q <= n_q + 7'h01;
                            st_q <= mbrw_pkg::MBRW_WR_REQ;
                        end
                    end
                end
                mbrw_pkg::MBRW_RD_REQ: begin
                    req_valid_q <= 1'b1;
                    req_q <= '{write: 1'b0, addr: rs_q + 16'(n_q), data: 16'h0000};
                    st_q <= mbrw_pkg::MBRW_RD_WAIT;
                end
                mbrw_pkg::MBRW_RD_WAIT: begin
                    if (req_ack_in) begin
                        req_valid_q <= 1'b0;
                        if (req_err_in) begin
                            kind_q <= mbrw_pkg::MBRW_KIND_EXC;
                            exc_q <= `MBRW_EXC_ADDR;
                            st_q <= mbrw_pkg::MBRW_TX;
                        end else if (n_last_rd) begin
                            kind_q <= mbrw_pkg::MBRW_KIND_RW;
                            st_q <= mbrw_pkg::MBRW_TX;
                        end else begin
                            n_q <= n_q + 7'h01;
                            st_q <= mbrw_pkg::MBRW_RD_REQ;
                        end
                    end
                end
                mbrw_pkg::MBRW_TX: begin
                    if (tx_load) begin
                        tx_valid_q <= 1'b1;
                        tx_q <= '{data: tx_byte, last: (tx_idx_q == tx_len - 8'h01)};
                        tx_idx_q <= tx_idx_q + 8'h01;
                    end else if (!tx_valid_q || tx_ready_in) begin
                        tx_valid_q <= 1'b0;
                        st_q <= mbrw_pkg::MBRW_IDLE;
                    end
                end
                default: st_q <= mbrw_pkg::MBRW_IDLE;
            endcase
        end
    end

    // busy flag for the frame engine
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (st_q != mbrw_pkg::MBRW_IDLE) || is_id || is_rw;
        end
    end

    // outputs straight from flops
    assign tx_out = tx_q;
    assign tx_valid_out = tx_valid_q;
    assign req_valid_out = req_valid_q;
    assign req_out = req_q;
    assign busy_out = busy_q;

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_rw_accept;
        is_rw && rw_ok;
    endsequence
    sequence s_first_write;
        st_q == mbrw_pkg::MBRW_WR_REQ ##1 (req_valid_q && req_q.write && req_q.addr == ws_q);
    endsequence

    a_drop_bad_frame: assert property (
        (st_q == mbrw_pkg::MBRW_IDLE && rx_end_in && (!rx_crc_ok_in || sa_q != own_q))
        |=> st_q == mbrw_pkg::MBRW_IDLE && !tx_valid_q) else $error("bad frame not dropped");
    a_rw_write_first: assert property (s_rw_accept |=> s_first_write)
        else $error("write phase did not start");
    a_rw_bad_qty: assert property (
        (is_rw && !rw_ok) |=> st_q == mbrw_pkg::MBRW_TX && is_exc && exc_q == `MBRW_EXC_VALUE)
        else $error("bad quantity not refused");
    a_store_refusal: assert property (
        ((st_q == mbrw_pkg::MBRW_WR_WAIT || st_q == mbrw_pkg::MBRW_RD_WAIT) && req_ack_in && req_err_in)
        |=> st_q == mbrw_pkg::MBRW_TX && is_exc && exc_q == `MBRW_EXC_ADDR)
        else $error("store refusal not reported");
    a_id_answer: assert property ((is_id && !id_fault_in) |=> st_q == mbrw_pkg::MBRW_TX && is_idk)
        else $error("identification not answered");
    a_id_run_byte: assert property ((tx_load && is_idk && tx_idx_q == 8'h04)
        |=> tx_q.data == ($past(run_status_in) ? `MBRW_RUN_ON : `MBRW_RUN_OFF))
        else $error("run status wrong");
    a_exc_fc_byte: assert property ((tx_load && is_exc && tx_idx_q == 8'h01)
        |=> tx_q.data == ($past(fc_q) | `MBRW_ERR_FLAG)) else $error("exception function byte wrong");
    a_id_exc_code: assert property ((tx_load && is_exc && fc_q == `MBRW_FC_ID && tx_idx_q == 8'h02)
        |=> tx_q.data == `MBRW_EXC_FUNC || tx_q.data == `MBRW_EXC_FAIL) else $error("bad id exception");
    a_rw_count_byte: assert property ((tx_load && kind_q == mbrw_pkg::MBRW_KIND_RW && tx_idx_q == 8'h02)
        |=> tx_q.data == {$past(rq_q[6:0]), 1'b0}) else $error("byte count wrong");
    a_req_hold: assert property ((req_valid_q && !req_ack_in) |=> req_valid_q && $stable(req_q))
        else $error("store request dropped early");
    a_tx_hold: assert property ((tx_valid_q && !tx_ready_in) |=> tx_valid_q && $stable(tx_q))
        else $error("answer byte changed while stalled");

endmodule

/* File: bench/mbrw_store_model.sv */
// behavioural register store answering the interpreter's word requests
`timescale 1ns/100ps

module mbrw_store_model (
    // clock
    input wire logic clk_in,
    // request side
    input wire logic req_valid_in,
    input wire mbrw_pkg::mbrw_req_type req_in,
    input wire logic slow_in,
    // answer side
    output logic ack_out,
    output logic [15:0] rdata_out,
    output logic err_out
);
    logic [2:0] wait_q = 3'h0;
    logic [15:0] wr_addr[0:7];
    logic [15:0] wr_data[0:7];
    int wr_count = 0;

    // answer after one or four cycles; read word is the inverted address
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        err_out <= ~err_out;
        rdata_out <= ~rdata_out;
        if (req_valid_in && !ack_out) begin
            if (wait_q != (slow_in ? 3'h3 : 3'h0)) begin
                wait_q <= wait_q + 3'h1;
            end else begin
                wait_q <= 3'h0;
                ack_out <= 1'b1;
                err_out <= (req_in.addr == 16'hdead);
                rdata_out <= ~req_in.addr;
                if (req_in.write) begin
                    wr_addr[wr_count[2:0]] <= req_in.addr;
                    wr_data[wr_count[2:0]] <= req_in.data;
                    wr_count <= wr_count + 1;
                end
            end
        end
    end

    initial begin
        ack_out = 1'b0;
        err_out = 1'b0;
        rdata_out = 16'h0000;
    end
endmodule

/* File: bench/modbus_server_id_and_rw_multi_test.sv */
// self-checking bench for the identification and read/write-multiple interpreter
`timescale 1ns/100ps
`include "mbrw_regs.svh"

module modbus_server_id_and_rw_multi_test;
    logic clk_in, rst_n_in, rx_valid_in, rx_end_in, rx_crc_ok_in, tx_ready_in, tx_valid_out;
    logic run_status_in, id_fault_in, slow_in, req_valid_out, req_ack_in, req_err_in, busy_out;
    logic [7:0] rx_data_in, server_addr_in;
    logic [15:0] req_rdata_in;
    mbrw_pkg::mbrw_tx_type tx_out;
    mbrw_pkg::mbrw_req_type req_out;
    int miscompares = 0;
    int checks_done = 0;
    logic stall = 1'b0;

    mbrw_server dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in),
        .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in), .tx_out(tx_out), .tx_valid_out(tx_valid_out),
        .tx_ready_in(tx_ready_in), .server_addr_in(server_addr_in), .run_status_in(run_status_in),
        .id_fault_in(id_fault_in), .req_valid_out(req_valid_out), .req_out(req_out), .req_ack_in(req_ack_in),
        .req_rdata_in(req_rdata_in), .req_err_in(req_err_in), .busy_out(busy_out));
    mbrw_store_model store (.clk_in(clk_in), .req_valid_in(req_valid_out), .req_in(req_out), .slow_in(slow_in),
        .ack_out(req_ack_in), .rdata_out(req_rdata_in), .err_out(req_err_in));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one byte a cycle, then the end pulse with the crc verdict
    task automatic send(input logic [7:0] f[$], input logic crc_ok);
        foreach (f[i]) begin
            @(negedge clk_in);
            rx_valid_in = 1'b1;
            rx_data_in = f[i];
        end
        @(negedge clk_in);
        rx_valid_in = 1'b0;
        rx_end_in = 1'b1;
        rx_crc_ok_in = crc_ok;
        @(negedge clk_in);
        rx_end_in = 1'b0;
    endtask

    task automatic idle_wait();
        int n;
        for (n = 0; n < 600 && busy_out !== 1'b0; n++) @(negedge clk_in);
        check("busy after answer", {15'h0, busy_out}, 16'h0000);
        if (busy_out !== 1'b0) final_report();
        repeat (2) @(negedge clk_in);
    endtask

    // collect the answer bytes, stalling the byte sink when asked
    task automatic answer(input logic [7:0] exp[$]);
        logic [8:0] got[$];
        int n;
        for (n = 0; n < 3000 && (got.size() == 0 || !got[$][0]); n++) begin
            @(negedge clk_in);
            tx_ready_in = !stall || (n % 3 != 0);
            if (tx_valid_out && tx_ready_in) got.push_back(tx_out);
        end
        check("answer length", 16'(got.size()), 16'(exp.size()));
        if (got.size() == 0) final_report();
        foreach (exp[i]) begin
            if (i < got.size()) begin
                check("answer byte", {8'h00, got[i][8:1]}, {8'h00, exp[i]});
                check("last flag", {15'h0, got[i][0]}, {15'h0, i == exp.size() - 1});
            end
        end
        tx_ready_in = 1'b1;
        idle_wait();
    endtask

    task automatic quiet();
        repeat (40) begin
            @(negedge clk_in);
            check("no answer", {15'h0, tx_valid_out | req_valid_out}, 16'h0000);
        end
    endtask

    function automatic void push16(ref logic [7:0] f[$], input logic [15:0] v);
        f.push_back(v[15:8]);
        f.push_back(v[7:0]);
    endfunction

    // combined request: read fields, write fields, byte count, values
    task automatic send_rw(input logic [15:0] rs, rc, ws, wc, input logic [15:0] w[$]);
        logic [7:0] f[$];
        f = {8'h05, `MBRW_FC_RW};
        push16(f, rs);
        push16(f, rc);
        push16(f, ws);
        push16(f, wc);
        f.push_back(8'(2 * w.size()));
        foreach (w[i]) push16(f, w[i]);
        send(f, 1'b1);
    endtask

    task automatic t_id(input logic run, input logic fault, input logic [7:0] exp[$]);
        run_status_in = run;
        id_fault_in = fault;
        send({8'h05, `MBRW_FC_ID}, 1'b1);
        answer(exp);
    endtask

    task automatic t_rw(input logic slow, input logic stl);
        int c0;
        c0 = store.wr_count;
        stall = stl;
        slow_in = slow;
        send_rw(16'h1388, 16'h0002, 16'h1770, 16'h0002, {16'h0102, 16'h0304});
        answer({8'h05, 8'h17, 8'h04, 8'hec, 8'h77, 8'hec, 8'h76});
        check("words written", 16'(store.wr_count - c0), 16'h0002);
        check("write addr 0", store.wr_addr[c0 % 8], 16'h1770);
        check("write data 0", store.wr_data[c0 % 8], 16'h0102);
        check("write addr 1", store.wr_addr[(c0 + 1) % 8], 16'h1771);
        check("write data 1", store.wr_data[(c0 + 1) % 8], 16'h0304);
        stall = 1'b0;
        slow_in = 1'b0;
    endtask

    task automatic t_faults();
        send_rw(16'h0000, 16'h007a, 16'h0000, 16'h0001, {16'h1234});
        answer({8'h05, 8'h97, 8'h03});
        send_rw(16'h0000, 16'h0000, 16'h0000, 16'h0001, {16'h1234});
        answer({8'h05, 8'h97, 8'h03});
        send_rw(16'h0000, 16'h0001, 16'h0000, 16'h0002, {16'h1234});
        answer({8'h05, 8'h97, 8'h03});
        send_rw(16'h0000, 16'h0001, 16'hdead, 16'h0001, {16'h5555});
        answer({8'h05, 8'h97, 8'h02});
        send_rw(16'hdead, 16'h0001, 16'h0000, 16'h0001, {16'h5555});
        answer({8'h05, 8'h97, 8'h02});
        send({8'h05, `MBRW_FC_ID, 8'h00}, 1'b1);
        quiet();
        send({8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
        quiet();
        send({8'h06, `MBRW_FC_ID}, 1'b1);
        quiet();
        send({8'h05, `MBRW_FC_ID}, 1'b0);
        quiet();
    endtask

    // reset in the middle of a store request, then check the answer valid, store request valid and busy outputs are idle
    task automatic t_reset();
        int n;
        slow_in = 1'b1;
        send_rw(16'h0010, 16'h0001, 16'h0020, 16'h0001, {16'h0abc});
        for (n = 0; n < 50 && req_valid_out !== 1'b1; n++) @(negedge clk_in);
        check("store request before reset", {15'h0, req_valid_out}, 16'h0001);
        rst_n_in = 1'b0;
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (2) begin
            check("idle after reset", {13'h0, tx_valid_out, req_valid_out, busy_out}, 16'h0000);
            @(negedge clk_in);
        end
        slow_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial begin
        rst_n_in = 1'b0;
        {rx_valid_in, rx_end_in, rx_crc_ok_in, run_status_in, id_fault_in, slow_in} = 6'h00;
        rx_data_in = 8'h00;
        tx_ready_in = 1'b1;
        server_addr_in = 8'h05;
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("answer idle after reset", {15'h0, tx_valid_out}, 16'h0000);
        repeat (3) @(negedge clk_in);
        t_id(1'b1, 1'b0, {8'h05, 8'h11, 8'h02, 8'h05, 8'hff});
        t_id(1'b0, 1'b0, {8'h05, 8'h11, 8'h02, 8'h05, 8'h00});
        t_id(1'b0, 1'b1, {8'h05, 8'h91, 8'h04});
        t_rw(1'b1, 1'b1);
        t_rw(1'b0, 1'b0);
        t_reset();
        t_faults();
        final_report();
    end
endmodule
